//--- logic/lft_timing.sv
// LCD common phase, frame and booster clock timing generator
`default_nettype none
module lft_timing
    import lft_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire lft_mode_s         i_mode,
    input  wire logic              i_fast_osc_clock,
    input  wire logic              i_slow_osc_clock,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [3:0]             o_com_select,
    output logic [1:0]             o_com_phase,
    output logic                   o_frame_pulse,
    output logic                   o_boost_clk,
    output logic                   o_booster_on
);
    lft_ctrl_s             ctrl_q;
    lft_ctrl_s             ctrl_d;
    logic [2:0]            fsync_q;
    logic [2:0]            fsync_d;
    logic [2:0]            ssync_q;
    logic [2:0]            ssync_d;
    logic [CNT_W-1:0]      fcnt_q;
    logic [CNT_W-1:0]      fcnt_d;
    logic [SLOW_CNT_W-1:0] scnt_q;
    logic [SLOW_CNT_W-1:0] scnt_d;
    logic [1:0]            phase_q;
    logic [1:0]            phase_d;
    logic                  frame_q;
    logic                  frame_d;
    logic                  bclk_q;
    logic                  bclk_d;
    logic [3:0]            comsel_q;
    logic [3:0]            comsel_d;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     rdata_d;
    logic                  boost_on_q;
    logic                  boost_on_d;
    logic                  fedge;
    logic                  sedge;
    logic                  slow_src;
    logic                  slow_frame;
    logic                  ptick;
    logic                  btick;
    logic [4:0]            pexp;
    logic [4:0]            bexp;
    logic [1:0]            last_phase;

    // True on the source edge that ends a 2^e count
    // Exponents above the counter width truncate to an all-ones mask and match once per counter wrap
    function automatic logic div_tick(input logic [CNT_W-1:0] cnt,
                                      input logic [4:0] e);
        logic [CNT_W-1:0] mask;
        mask = CNT_W'((32'h1 << e) - 32'h1);
        return (cnt & mask) == mask;
    endfunction

    // Oscillators are foreign; only the second and third stages feed the edge logic
    always_comb
    begin
        fsync_d = {fsync_q[1:0], i_fast_osc_clock};
        ssync_d = {ssync_q[1:0], i_slow_osc_clock};
        fedge   = fsync_q[1] & ~fsync_q[2];
        sedge   = ssync_q[1] & ~ssync_q[2];
        // Counters free-run, so a new setting takes the next matching
        // count and its first step may come early
        fcnt_d  = fedge ? fcnt_q + 1'b1 : fcnt_q;
        scnt_d  = sedge ? scnt_q + 1'b1 : scnt_q;
    end

    // Source and divider choice
    always_comb
    begin
        // Low speed run mode alone does not move the source
        slow_src = i_mode.dual_clock_mode & (i_mode.slow_divider_source
                   | i_mode.system_clock_select);
        // Settings 10/11 have no slow divider; they stay on the fast one
        slow_frame = slow_src & ~ctrl_q.frame_rate_select[1];
        if (slow_frame)
        begin
            pexp  = BASE_SLOW_EXP[ctrl_q.frame_rate_select[0]];
            ptick = sedge;
        end
        else
        begin
            pexp  = BASE_FAST_EXP[ctrl_q.frame_rate_select];
            ptick = fedge;
        end
        // Quarter, third and half all step commons at four times base
        if (ctrl_q.drive_method_select != DM_STATIC)
            pexp = pexp - PHASE_SHIFT;
        ptick = ptick & div_tick(slow_frame ? {8'hff, scnt_q} : fcnt_q,
                                 pexp);
        // Toggle at half the period to make a square boost clock
        if (slow_src && ctrl_q.boost_rate_select != 2'h3)
        begin
            bexp  = BOOST_SLOW_EXP[ctrl_q.boost_rate_select] - 5'd1;
            btick = sedge & div_tick({8'hff, scnt_q}, bexp);
        end
        else
        begin
            bexp  = BOOST_FAST_EXP[ctrl_q.boost_rate_select] - 5'd1;
            btick = fedge & div_tick(fcnt_q, bexp);
        end
    end

    // Common phase sequencing
    always_comb
    begin
        unique case (ctrl_q.drive_method_select)
            DM_QUARTER: last_phase = 2'h3;
            DM_THIRD:   last_phase = 2'h2;
            DM_HALF:    last_phase = 2'h1;
            DM_STATIC:  last_phase = 2'h0;
        endcase
        phase_d = phase_q;
        frame_d = 1'b0;
        // A shorter method written while the phase is past its last common restarts at common 0
        if (phase_q > last_phase)
            phase_d = 2'h0;
        else if (ptick)
        begin
            if (phase_q == last_phase)
            begin
                phase_d = 2'h0;
                frame_d = 1'b1;
            end
            else
                phase_d = phase_q + 2'h1;
        end
        // Select lines follow the next phase so they match o_com_phase
        comsel_d = 4'h1 << phase_d;
        // Booster idles low when the resistor divider supplies levels
        bclk_d = ctrl_q.booster_enable ? bclk_q ^ btick : 1'b0;
    end

    // Register port
    always_comb
    begin
        ctrl_d  = ctrl_q;
        rdata_d = '0;
        // Writes elsewhere are dropped; status is read-only
        if (i_wr && i_addr == OFS_CONTROL)
            ctrl_d = lft_ctrl_s'(i_wdata[6:0]);
        // Bit 7 is not stored and reads back as 0
        // Status shows the live booster clock, source and common
        if (i_rd)
        begin
            unique case (i_addr)
                OFS_CONTROL: rdata_d = {1'b0, ctrl_q};
                OFS_STATUS:  rdata_d = {4'h0, bclk_q, slow_src, phase_q};
                default:     rdata_d = '0;
            endcase
        end
    end

    // Reset is synchronous, like every other register here
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ctrl_q   <= CONTROL_RESET;
            fsync_q  <= '0;
            ssync_q  <= '0;
            fcnt_q   <= '0;
            scnt_q   <= '0;
            phase_q  <= '0;
            frame_q  <= 1'b0;
            bclk_q   <= 1'b0;
            comsel_q <= 4'h1;
            rdata_q  <= '0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            fsync_q  <= fsync_d;
            ssync_q  <= ssync_d;
            fcnt_q   <= fcnt_d;
            scnt_q   <= scnt_d;
            phase_q  <= phase_d;
            frame_q  <= frame_d;
            bclk_q   <= bclk_d;
            comsel_q <= comsel_d;
            rdata_q  <= rdata_d;
        end
    end

    // Booster on flag follows the control bit one cycle later
    always_comb
        boost_on_d = ctrl_q.booster_enable;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            boost_on_q <= 1'b0;
        else
            boost_on_q <= boost_on_d;
    end

    assign o_rdata       = rdata_q;
    assign o_com_select  = comsel_q;
    assign o_com_phase   = phase_q;
    assign o_frame_pulse = frame_q;
    assign o_boost_clk   = bclk_q;
    assign o_booster_on  = boost_on_q;
endmodule
`default_nettype wire

//--- logic/lft_pkg.sv
// Package for the LCD frame and boost timing block
`default_nettype none
package lft_pkg;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 8;
    localparam logic [3:0]  OFS_CONTROL   = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [6:0]  CONTROL_RESET = 7'h00;
    localparam int unsigned CNT_W         = 17;
    localparam int unsigned SLOW_CNT_W    = 9;

    // Drive methods as held in drive_method_select
    localparam logic [1:0] DM_QUARTER = 2'h0;
    localparam logic [1:0] DM_THIRD   = 2'h1;
    localparam logic [1:0] DM_HALF    = 2'h2;
    localparam logic [1:0] DM_STATIC  = 2'h3;

    // Base frequency divider exponents, fast then slow source
    localparam logic [4:0] BASE_FAST_EXP [4] = '{5'd17, 5'd16, 5'd15, 5'd13};
    localparam logic [4:0] BASE_SLOW_EXP [2] = '{5'd9, 5'd8};
    // Booster clock divider exponents (full period)
    localparam logic [4:0] BOOST_FAST_EXP [4] = '{5'd13, 5'd11, 5'd10, 5'd9};
    localparam logic [4:0] BOOST_SLOW_EXP [3] = '{5'd5, 5'd3, 5'd2};
    // Phase step is base/4 for every multiplexed method
    localparam logic [4:0] PHASE_SHIFT = 5'd2;

    // Bit layout of lcd_control_reg
    localparam int unsigned BIT_BOOST_EN  = 6;
    localparam int unsigned POS_BOOST_SEL = 4;
    localparam int unsigned POS_DRIVE     = 2;
    localparam int unsigned POS_FRAME     = 0;

    typedef struct packed {
        logic       booster_enable;
        logic [1:0] boost_rate_select;
        logic [1:0] drive_method_select;
        logic [1:0] frame_rate_select;
    } lft_ctrl_s;

    typedef struct packed {
        logic       dual_clock_mode;
        logic       slow_divider_source;
        logic       system_clock_select;
        logic       low_speed_run_mode;
    } lft_mode_s;
endpackage
`default_nettype wire

//--- test/lft_timing_assertions.sv
// Checker for the LCD frame and boost timing block
`default_nettype none
module lft_timing_assertions
    import lft_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic [3:0]        o_com_select,
    input wire logic [1:0]        o_com_phase,
    input wire logic              o_frame_pulse,
    input wire logic              o_boost_clk,
    input wire logic              o_booster_on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] ctl_q;
    // Shadow of the control fields so timing can be tied to the setting
    always_ff @(posedge i_clk_sys)
        if (!i_rst_n)
            ctl_q <= 7'h00;
        else if (i_wr && i_addr == OFS_CONTROL)
            ctl_q <= i_wdata[6:0];
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    AST_CTL_RD: assert property ($past(i_rd)
        && $past(i_addr) == OFS_CONTROL
        |-> o_rdata == {1'b0, $past(ctl_q)}) else $error("control readback");
    AST_ONE_HOT: assert property (o_com_select == 4'h1 << o_com_phase)
        else $error("common select not one-hot");
    AST_STEP: assert property ($changed(o_com_phase)
        |-> o_com_phase == $past(o_com_phase) + 2'h1 || o_com_phase == 2'h0)
        else $error("phase skipped");
    AST_LIMIT: assert property ($stable(ctl_q)
        |-> o_com_phase <= 2'h3 - ctl_q[3:2]) else $error("phase too high");
    AST_WRAP: assert property (o_frame_pulse && $stable(ctl_q)
        |-> $past(o_com_phase) == 2'h3 - ctl_q[3:2]) else $error("bad wrap");
    AST_PULSE: assert property (o_frame_pulse
        |-> o_com_phase == 2'h0 ##1 !o_frame_pulse) else $error("bad pulse");
    AST_BOOST_ON: assert property (ctl_q[6] |=> o_booster_on)
        else $error("booster not on");
    AST_BOOST_GATE: assert property (!o_booster_on |-> !o_boost_clk)
        else $error("boost clock while off");
endmodule
bind lft_timing lft_timing_assertions i_chk (.i_clk_sys, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_com_select, .o_com_phase,
    .o_frame_pulse, .o_boost_clk, .o_booster_on);
`default_nettype wire

//--- test/lft_panel_model.sv
// Passive panel model that reports how many commons a frame visited
`default_nettype none
module lft_panel_model
(
    input  wire logic       i_clk_sys,
    input  wire logic [1:0] i_com_phase,
    input  wire logic       i_frame_pulse,
    output logic      [2:0] o_commons
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] top_q = 2'h0;
    always @(posedge i_clk_sys)
    begin
        if (i_frame_pulse)
        begin
            o_commons <= {1'b0, top_q} + 3'h1;
            top_q <= 2'h0;
        end
        else if (i_com_phase > top_q)
            top_q <= i_com_phase;
    end
endmodule
`default_nettype wire

//--- test/lft_timing_bench.sv
// Bench for the LCD frame and boost timing block
`default_nettype none
module lft_timing_bench
    import lft_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk_sys = 1'b0;
    logic       i_rst_n   = 1'b0;
    logic [3:0] i_addr    = 4'h0;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    lft_mode_s  i_mode    = '0;
    logic [1:0] osc_q     = 2'h0;
    logic [7:0] o_rdata, v;
    logic [3:0] o_com_select;
    logic [1:0] o_com_phase;
    logic [2:0] commons;
    logic       o_frame_pulse, o_boost_clk, o_booster_on;
    int         num_errors = 0, num_checks = 0, n, base, bx[4] = '{5, 3, 2, 9};
    lft_timing i_dut (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .i_mode, .i_fast_osc_clock(osc_q[1]), .i_slow_osc_clock(osc_q[1]),
        .o_rdata, .o_com_select, .o_com_phase, .o_frame_pulse, .o_boost_clk,
        .o_booster_on);
    lft_panel_model i_panel (.i_clk_sys, .i_com_phase(o_com_phase),
        .i_frame_pulse(o_frame_pulse), .o_commons(commons));
    initial
        forever #2 i_clk_sys = ~i_clk_sys;
    // Both oscillators rise every 4 system cycles, slow enough to sync
    always @(posedge i_clk_sys)
        osc_q <= osc_q + 2'h1;
    task automatic check(input string s, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %0h seen %0h", s, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // First interval may be cut short by the free-running dividers
    task automatic gap(input logic b);
        logic p, s, e;
        p = 1'b1;
        repeat (2)
            for (n = 1; n < 70000; n++)
            begin
                @(posedge i_clk_sys);
                #1 s = b ? o_boost_clk : o_frame_pulse;
                e = s && !p;
                p = s;
                if (e)
                    break;
            end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        #1 check("reset", {o_com_select, o_com_phase, o_frame_pulse,
            o_boost_clk, o_booster_on, o_rdata}, {4'h1, 13'h0000});
        acc(0, OFS_CONTROL, 8'h00);
        check("ctl reset", v, {1'b0, CONTROL_RESET});
        acc(1, OFS_CONTROL, 8'hc1);
        acc(1, 4'h8, 8'h3e);
        acc(1, OFS_STATUS, 8'hff);
        acc(0, OFS_CONTROL, 8'h00);
        check("ctl", v, 8'h41);
        acc(0, 4'h8, 8'h00);
        check("unmapped", v, 8'h00);
        acc(0, OFS_STATUS, 8'h00);
        check("status top", v[7:4], 4'h0);
        check("booster on", o_booster_on, 1'b1);
        @(posedge i_clk_sys) i_mode <= '{1'b1, 1'b0, 1'b1, 1'b1};
        for (int m = 0; m < 8; m++)
        begin
            acc(1, OFS_CONTROL, {4'h0, m[2:1], 1'b0, m[0]});
            base = 1 << (9 - m[0]);
            base = m[2:1] == 3 ? base : (4 - m[2:1]) * base / 4;
            gap(1'b0);
            check("frame", n, 4 * base);
            // The panel takes the frame pulse one edge later
            @(posedge i_clk_sys);
            #1 check("commons", commons, 4 - m[2:1]);
        end
        acc(0, OFS_STATUS, 8'h00);
        check("slow source", v[2], 1'b1);
        @(posedge i_clk_sys) i_mode <= '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int m = 0; m < 4; m++)
        begin
            acc(1, OFS_CONTROL, {2'h1, m[1:0], 4'h1});
            gap(1'b1);
            check("boost", n, 4 << bx[m]);
        end
        @(posedge i_clk_sys) i_mode <= '0;
        acc(1, OFS_CONTROL, {4'h0, DM_HALF, 2'h3});
        gap(1'b0);
        check("fast frame", n, 4 << 12);
        conclude();
    end
    initial
    begin
        repeat (80000) @(posedge i_clk_sys);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
